// File: design/msr_time_reg.sv
// minutes-and-seconds BCD time register with software port and hardware advance
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
module msr_time_reg (
  // clock and reset
  input  wire logic                           sys_clk_i,
  input  wire logic                           rst_i,
  // register port
  input  wire logic [msr_pkg::MSR_ADDR_W-1:0] addr_i,
  input  wire logic [msr_pkg::MSR_DATA_W-1:0] wdata_i,
  input  wire logic                           we_i,
  input  wire logic                           re_i,
  output logic      [msr_pkg::MSR_DATA_W-1:0] rdata_o,
  // timekeeping
  input  wire logic                           sec_tick_i,
  output logic                                hour_carry_o,
  output logic                                time_valid_o,
  output logic      [msr_pkg::MSR_DATA_W-1:0] time_o
);
  import msr_pkg::*;

  // digit flops carry no reset: the time is undefined until software sets it
  logic [2:0]  minute_tens_digit_q;   // minute tens
  logic [3:0]  minute_ones_digit_q;   // minute ones
  logic [2:0]  second_tens_digit_q;   // second tens
  logic [3:0]  second_ones_digit_q;   // second ones
  logic [2:0]  minute_tens_digit_d;
  logic [3:0]  minute_ones_digit_d;
  logic [2:0]  second_tens_digit_d;
  logic [3:0]  second_ones_digit_d;
  logic        valid_q;               // set by the first software write
  logic        carry_q;               // one-cycle carry to the hour register
  logic [15:0] rdata_q;               // read data, one cycle after the strobe
  logic [15:0] time_q;                // registered copy of the time value

  // address decode
  wire         hit     = (addr_i == MSR_TIME_OFS);
  wire         wr_hit  = we_i & hit;
  wire         rd_hit  = re_i & hit;

  // write fields; bits 15 and 7 are never looked at
  wire [2:0]   w_mt    = wdata_i[MSR_MT_LSB +: 3];
  wire [3:0]   w_mo    = wdata_i[MSR_MO_LSB +: 4];
  wire [2:0]   w_st    = wdata_i[MSR_ST_LSB +: 3];
  wire [3:0]   w_so    = wdata_i[MSR_SO_LSB +: 4];

  // an out-of-range digit is refused and that field keeps its value
  wire         w_mt_ok = (w_mt <= MSR_TEN_MAX);
  wire         w_mo_ok = (w_mo <= MSR_ONE_MAX);
  wire         w_st_ok = (w_st <= MSR_TEN_MAX);
  wire         w_so_ok = (w_so <= MSR_ONE_MAX);

  // BCD carry chain for one second step
  wire         so_wrap = (second_ones_digit_q == MSR_ONE_MAX);
  wire         st_wrap = so_wrap & (second_tens_digit_q == MSR_TEN_MAX);
  wire         mo_wrap = st_wrap & (minute_ones_digit_q == MSR_ONE_MAX);
  wire         mt_wrap = mo_wrap & (minute_tens_digit_q == MSR_TEN_MAX);

  // next digit values on a tick; each digit wraps at its own limit
  wire [3:0]   so_nx   = so_wrap ? MSR_ONE_ZERO : second_ones_digit_q + MSR_ONE_STEP;
  wire [2:0]   st_nx   = !so_wrap ? second_tens_digit_q :
                         st_wrap ? MSR_TEN_ZERO : second_tens_digit_q + MSR_TEN_STEP;
  wire [3:0]   mo_nx   = !st_wrap ? minute_ones_digit_q :
                         mo_wrap ? MSR_ONE_ZERO : minute_ones_digit_q + MSR_ONE_STEP;
  wire [2:0]   mt_nx   = !mo_wrap ? minute_tens_digit_q :
                         mt_wrap ? MSR_TEN_ZERO : minute_tens_digit_q + MSR_TEN_STEP;

  // hardware advances only when software is not writing this cycle
  wire         adv     = sec_tick_i & ~wr_hit;

  // software write wins over a tick in the same cycle; the tick is dropped
  assign second_ones_digit_d = wr_hit ? (w_so_ok ? w_so : second_ones_digit_q) :
                               adv ? so_nx : second_ones_digit_q;
  assign second_tens_digit_d = wr_hit ? (w_st_ok ? w_st : second_tens_digit_q) :
                               adv ? st_nx : second_tens_digit_q;
  assign minute_ones_digit_d = wr_hit ? (w_mo_ok ? w_mo : minute_ones_digit_q) :
                               adv ? mo_nx : minute_ones_digit_q;
  assign minute_tens_digit_d = wr_hit ? (w_mt_ok ? w_mt : minute_tens_digit_q) :
                               adv ? mt_nx : minute_tens_digit_q;

  // register image; unimplemented bits forced to zero
  wire [15:0]  image   = {1'b0, minute_tens_digit_q, minute_ones_digit_q,
                          1'b0, second_tens_digit_q, second_ones_digit_q};

  // digit storage, deliberately outside reset
  // a reset here would hide the undefined power-on time that software must set;
  // the price is that nothing downstream may trust the digits before a write
  always_ff @(posedge sys_clk_i) begin
    minute_tens_digit_q <= minute_tens_digit_d;
    minute_ones_digit_q <= minute_ones_digit_d;
    second_tens_digit_q <= second_tens_digit_d;
    second_ones_digit_q <= second_ones_digit_d;
  end

  // control and output flops
  // read data fall back to zero when no read is pending, so the port idles low;
  // the carry is registered so the hour register sees one clean pulse
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      carry_q <= 1'b0;
      rdata_q <= MSR_RDATA_RST;
      time_q  <= MSR_RDATA_RST;
    end else begin
      valid_q <= valid_q | wr_hit;
      carry_q <= adv & mt_wrap;
      rdata_q <= rd_hit ? image : MSR_RDATA_RST;
      time_q  <= image;
    end
  end

  // every output comes straight from a flop, with no logic after it
  assign rdata_o      = rdata_q;
  assign hour_carry_o = carry_q;
  assign time_valid_o = valid_q;
  assign time_o       = time_q;

  // checks, active once software has set the time
  // the digits are undefined before the first write, so most checks are
  // gated by valid_q; a first write that refuses a field leaves that field
  // undefined, which software must avoid

  // ---- digit ranges ----

  // minute tens never leaves 0 to 5
  // a refused write or a wrap must both keep it in range
  a_min_tens_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q |-> minute_tens_digit_q <= MSR_TEN_MAX)
    else $error("minute tens digit out of range");

  // minute ones never leaves 0 to 9
  // a four-bit field could hold up to 15, so this is not free
  a_min_ones_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q |-> minute_ones_digit_q <= MSR_ONE_MAX)
    else $error("minute ones digit out of range");

  // second tens never leaves 0 to 5
  // a three-bit field could hold up to 7
  a_sec_tens_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q |-> second_tens_digit_q <= MSR_TEN_MAX)
    else $error("second tens digit out of range");

  // second ones never leaves 0 to 9
  // this digit moves every tick, so it sees the most wraps
  a_sec_ones_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q |-> second_ones_digit_q <= MSR_ONE_MAX)
    else $error("second ones digit out of range");

  // ---- refused writes ----

  // an out-of-range minute tens keeps the old digit
  // the other fields of the same word are judged on their own
  a_bad_min_tens_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_hit && !w_mt_ok |=> minute_tens_digit_q == $past(minute_tens_digit_q))
    else $error("refused minute tens digit stored");

  // an out-of-range minute ones keeps the old digit
  // values 10 to 15 are not BCD
  a_bad_min_ones_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_hit && !w_mo_ok |=> minute_ones_digit_q == $past(minute_ones_digit_q))
    else $error("refused minute ones digit stored");

  // an out-of-range second tens keeps the old digit
  // values 6 and 7 would break the minute carry
  a_bad_sec_tens_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_hit && !w_st_ok |=> second_tens_digit_q == $past(second_tens_digit_q))
    else $error("refused second tens digit stored");

  // an out-of-range second ones keeps the old digit
  // values 10 to 15 would never reach the wrap compare
  a_bad_sec_ones_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_hit && !w_so_ok |=> second_ones_digit_q == $past(second_ones_digit_q))
    else $error("refused second ones digit stored");

  // ---- unimplemented bits and read port ----

  // bits 15 and 7 read as zero whatever was written
  // the image ties them low, so this guards the concatenation order
  a_unimpl_read_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    re_i |=> rdata_o[15] == 1'b0 && rdata_o[7] == 1'b0)
    else $error("unimplemented bit read as one");

  // a read of the register returns the image of the cycle it was taken
  // a tick in that same cycle shows only on the next read
  a_read_image: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q && rd_hit |=> rdata_o == $past(image))
    else $error("read data mismatch");

  // read data stand for one cycle only and idle at zero
  // a master that samples late sees zero, not stale data
  a_rdata_idle_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !re_i |=> rdata_o == MSR_RDATA_RST)
    else $error("read data not zero when idle");

  // a read of an unmapped address returns zero
  // only one word is decoded in this block
  a_unmapped_read_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    re_i && !hit |=> rdata_o == MSR_RDATA_RST)
    else $error("unmapped read not zero");

  // ---- software writes ----

  // a legal write lands in second ones and minute tens
  // checked the cycle after the strobe
  a_write_stores_digits: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_hit && w_so_ok && w_mt_ok |=> second_ones_digit_q == $past(w_so) &&
      minute_tens_digit_q == $past(w_mt))
    else $error("software write not stored");

  // a legal write lands in minute ones and second tens
  // together with the check above every field is covered
  a_write_stores_middle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_hit && w_mo_ok && w_st_ok |=> minute_ones_digit_q == $past(w_mo) &&
      second_tens_digit_q == $past(w_st))
    else $error("software write not stored in middle digits");

  // a write beats a tick in the same cycle
  // the tick is lost, which costs software one second at most
  a_write_drops_tick: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_hit && sec_tick_i && w_so_ok |=> second_ones_digit_q == $past(w_so))
    else $error("tick not dropped under a write");

  // ---- hardware advance ----

  // a tick steps second ones by one below its wrap
  // the lower digit moves on every tick
  a_tick_advances: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q && adv && !so_wrap |=> second_ones_digit_q == $past(second_ones_digit_q) + 4'h1)
    else $error("tick did not advance second ones");

  // second ones goes from nine back to zero
  // a missed wrap would leave a non-BCD value
  a_sec_ones_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q && adv && so_wrap |=> second_ones_digit_q == MSR_ONE_ZERO)
    else $error("second ones did not wrap");

  // second tens steps on the ones wrap
  // but not when it is already at five
  a_sec_tens_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q && adv && so_wrap && !st_wrap |=>
      second_tens_digit_q == $past(second_tens_digit_q) + 3'h1)
    else $error("second tens did not step");

  // second tens goes from five back to zero at 59
  // six would be an illegal second count
  a_sec_tens_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q && adv && st_wrap |=> second_tens_digit_q == MSR_TEN_ZERO)
    else $error("second tens did not wrap");

  // minute ones steps when the seconds roll over
  // but not when it is already at nine
  a_min_ones_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q && adv && st_wrap && !mo_wrap |=>
      minute_ones_digit_q == $past(minute_ones_digit_q) + 4'h1)
    else $error("minute ones did not step");

  // minute tens steps when minute ones rolls over
  // but not when it is already at five
  a_min_tens_step: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q && adv && mo_wrap && !mt_wrap |=>
      minute_tens_digit_q == $past(minute_tens_digit_q) + 3'h1)
    else $error("minute tens did not step");

  // without a tick or a write, second ones and minute tens hold
  // a spurious advance would drift the clock
  a_digits_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q && !sec_tick_i && !wr_hit |=> $stable(second_ones_digit_q) &&
      $stable(minute_tens_digit_q))
    else $error("digits moved without a tick");

  // ---- carry and copies ----

  // the hour carry is one pulse at 59:59
  // the hour register counts each pulse once
  a_hour_carry: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q && adv && mt_wrap |=> hour_carry_o ##1 !hour_carry_o)
    else $error("hour carry not a single pulse at wrap");

  // no carry except after a full wrap
  // a stray carry would advance the hour by one
  a_carry_only_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q && !(adv && mt_wrap) |=> !hour_carry_o)
    else $error("hour carry without a wrap");

  // the carry never lasts two cycles
  // two wraps in a row cannot happen
  a_carry_pulse_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    hour_carry_o |=> !hour_carry_o)
    else $error("hour carry held too long");

  // the time copy follows the image one cycle behind
  // readers of the copy see the same value as a register read
  a_time_copy: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q |=> time_o == $past(image))
    else $error("time copy mismatch");

  // ---- validity flag ----

  // once set, the valid flag stays set until reset
  // software has no way to clear it
  a_valid_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q |=> time_valid_o)
    else $error("valid flag dropped");

  // only a write to the register sets the valid flag
  // a read or a tick leaves the time undefined
  a_valid_only_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !valid_q && !wr_hit |=> !time_valid_o)
    else $error("valid flag set without a write");

  // ---- main scenarios reached ----

  // full wrap, write against tick, refused digit, read after write, tens wrap
  c_full_wrap:   cover property (@(posedge sys_clk_i) disable iff (rst_i) valid_q && adv && mt_wrap);
  c_write_tick:  cover property (@(posedge sys_clk_i) disable iff (rst_i) wr_hit && sec_tick_i);
  c_bad_write:   cover property (@(posedge sys_clk_i) disable iff (rst_i) wr_hit && !w_mo_ok);
  c_read_after:  cover property (@(posedge sys_clk_i) disable iff (rst_i) wr_hit ##1 rd_hit);
  c_tens_wrap:   cover property (@(posedge sys_clk_i) disable iff (rst_i)
    valid_q && adv && st_wrap && !mt_wrap);
endmodule : msr_time_reg

// File: inc/msr_pkg.sv
// constants for the minutes-and-seconds time register
package msr_pkg;
  localparam int unsigned MSR_ADDR_W    = 4;       // register port address width
  localparam int unsigned MSR_DATA_W    = 16;      // register width
  localparam logic [3:0]  MSR_TIME_OFS  = 4'h0;    // offset of minutes_seconds_time
  localparam logic [15:0] MSR_RDATA_RST = 16'h0000; // read data after reset / unmapped
  localparam int unsigned MSR_MT_LSB    = 12;      // minute tens field position
  localparam int unsigned MSR_MO_LSB    = 8;       // minute ones field position
  localparam int unsigned MSR_ST_LSB    = 4;       // second tens field position
  localparam int unsigned MSR_SO_LSB    = 0;       // second ones field position
  localparam logic [2:0]  MSR_TEN_MAX   = 3'h5;    // largest tens digit
  localparam logic [3:0]  MSR_ONE_MAX   = 4'h9;    // largest ones digit
  localparam logic [2:0]  MSR_TEN_ZERO  = 3'h0;    // tens digit after a wrap
  localparam logic [3:0]  MSR_ONE_ZERO  = 4'h0;    // ones digit after a wrap
  localparam logic [2:0]  MSR_TEN_STEP  = 3'h1;    // tens increment
  localparam logic [3:0]  MSR_ONE_STEP  = 4'h1;    // ones increment
endpackage : msr_pkg

// File: sim/tb_top.sv
// self-checking bench for the minutes-and-seconds time register
`timescale 1ns/1ps
module tb_top;
  import msr_pkg::*;
  logic        sys_clk_i   = 1'b0;   // 40 MHz system clock
  logic        rst_i       = 1'b1;   // synchronous reset, held at start
  logic [3:0]  addr_i      = 4'h0;   // register address
  logic [15:0] wdata_i     = 16'h0000; // write data
  logic        we_i        = 1'b0;   // write strobe
  logic        re_i        = 1'b0;   // read strobe
  logic        sec_tick_i  = 1'b0;   // one-second advance
  logic [15:0] rdata_o;              // read data
  logic        hour_carry_o;         // rollover pulse
  logic        time_valid_o;         // set once software has written
  logic [15:0] time_o;               // register image
  int          n_errors    = 0;      // mismatches
  int          checks      = 0;      // comparisons made
  int          cyc         = 0;      // timeout counter
  logic [15:0] ladder [4][2] = '{'{16'h0009, 16'h0010}, '{16'h0059, 16'h0100},
                                 '{16'h0959, 16'h1000}, '{16'h1234, 16'h1235}};
  msr_time_reg dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .sec_tick_i(sec_tick_i), .hour_carry_o(hour_carry_o),
    .time_valid_o(time_valid_o), .time_o(time_o));
  // clock: half period 12.5 ns
  always #12.5 sys_clk_i = ~sys_clk_i;
  // cut a hang short; the whole run needs well under 400 cycles
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end
  // compare with case equality so an unknown never passes
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i) begin
      we_i <= 1'b1; addr_i <= a; wdata_i <= d;
    end
    @(posedge sys_clk_i) we_i <= 1'b0;
  endtask : wr
  // one-cycle read strobe; data stand only in the following cycle
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i) begin
      re_i <= 1'b1; addr_i <= a;
    end
    @(posedge sys_clk_i) re_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rd
  // n back-to-back ticks
  task automatic tick(input int n);
    @(posedge sys_clk_i) sec_tick_i <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
    sec_tick_i <= 1'b0;
    #1;
  endtask : tick
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1 chk({15'h0000, time_valid_o}, 16'h0000);
    wr(MSR_TIME_OFS, 16'h5959);
    rd(MSR_TIME_OFS, 16'h5959);
    chk({15'h0000, time_valid_o}, 16'h0001);
    tick(1);
    chk({15'h0000, hour_carry_o}, 16'h0001);
    rd(MSR_TIME_OFS, 16'h0000);
    chk({15'h0000, hour_carry_o}, 16'h0000);
    chk(time_o, 16'h0000);
    $display("test rollover done");
    wr(MSR_TIME_OFS, 16'hA5A5);
    rd(MSR_TIME_OFS, 16'h2525);
    wr(MSR_TIME_OFS, 16'h1A3B);
    rd(MSR_TIME_OFS, 16'h1535);
    wr(MSR_TIME_OFS, 16'h6A6A);
    rd(MSR_TIME_OFS, 16'h1535);
    $display("test field limits done");
    for (int i = 0; i < 4; i++) begin
      wr(MSR_TIME_OFS, ladder[i][0]);
      tick(1);
      rd(MSR_TIME_OFS, ladder[i][1]);
    end
    wr(MSR_TIME_OFS, 16'h0058);
    tick(2);
    rd(MSR_TIME_OFS, 16'h0100);
    $display("test carries done");
    wr(4'h3, 16'h1111);
    rd(4'h3, 16'h0000);
    rd(MSR_TIME_OFS, 16'h0100);
    $display("test unmapped done");
    // a write and a tick in one cycle: the write wins, the tick is dropped
    @(posedge sys_clk_i) begin
      we_i <= 1'b1; addr_i <= MSR_TIME_OFS; wdata_i <= 16'h0304; sec_tick_i <= 1'b1;
    end
    @(posedge sys_clk_i) begin
      we_i <= 1'b0; sec_tick_i <= 1'b0;
    end
    rd(MSR_TIME_OFS, 16'h0304);
    // reset in mid-run clears control flops, digits stay as they were
    @(posedge sys_clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    #1 chk({14'h0000, time_valid_o, hour_carry_o}, 16'h0000);
    chk(time_o, 16'h0000);
    rd(MSR_TIME_OFS, 16'h0304);
    chk({15'h0000, time_valid_o}, 16'h0000);
    $display("test collision and reset done");
    end_of_test();
  end
endmodule : tb_top
